// ===== logic/ascg_map.vh
// register offsets, field codes, reset values and timing counts of the start/pin0 block
`ifndef ASCG_MAP_VH
`define ASCG_MAP_VH

// register offsets on the serial port
`define ASCG_ADDR_POWER      7'h00
`define ASCG_ADDR_CONV       7'h01
`define ASCG_ADDR_SEQ        7'h02
`define ASCG_ADDR_CAL        7'h03
`define ASCG_ADDR_PIN0       7'h04
`define ASCG_ADDR_GPCONV     7'h06
`define ASCG_ADDR_GPSEQ      7'h07
`define ASCG_ADDR_FILTER     7'h08
`define ASCG_ADDR_PGA        7'h0E

// serial frame layout
`define ASCG_FRAME_RW_BIT    7
`define ASCG_FRAME_BITS      5'h10
`define ASCG_CMD_LAST_BIT    5'h07
`define ASCG_DATA_LAST_BIT   5'h0F

// power-state codes and reset value
`define ASCG_PS_NORMAL       2'h0
`define ASCG_PS_STANDBY      2'h1
`define ASCG_PS_SLEEP        2'h2
`define ASCG_PS_RESET        2'h3
`define ASCG_PS_RST_VAL      2'h2
`define ASCG_PS_WAKE_READ    2'h2

// sequencer address ranges
`define ASCG_SEQ_MIN         7'h3A
`define ASCG_SEQ_MAX         7'h6E
`define ASCG_GPSEQ_MAX       7'h6F
`define ASCG_GPSEQ_RST_VAL   7'h3A

// calibration type codes
`define ASCG_CAL_SELF        3'h0
`define ASCG_CAL_PGA         3'h1
`define ASCG_CAL_RSV0        3'h2
`define ASCG_CAL_RSV1        3'h3
`define ASCG_CAL_SOFF_A      3'h4
`define ASCG_CAL_SGAIN_A     3'h5
`define ASCG_CAL_SOFF_B      3'h6
`define ASCG_CAL_SGAIN_B     3'h7

// calibration store targets
`define ASCG_OFF_SEL_SELF    2'h0
`define ASCG_OFF_SEL_SYS_A   2'h1
`define ASCG_OFF_SEL_SYS_B   2'h2
`define ASCG_GAIN_SEL_SYS_A  4'h8
`define ASCG_GAIN_SEL_SYS_B  4'h9
`define ASCG_GAIN_1X         3'h0
`define ASCG_PATH_PGA        2'h2

// pin0 control fields and codes
`define ASCG_DIR_MSB         7
`define ASCG_DIR_LSB         6
`define ASCG_ISEL_MSB        5
`define ASCG_ISEL_LSB        4
`define ASCG_OSEL_MSB        2
`define ASCG_OSEL_LSB        0
`define ASCG_DIR_IN          2'h0
`define ASCG_DIR_RSV         2'h1
`define ASCG_DIR_OD          2'h2
`define ASCG_DIR_PP          2'h3
`define ASCG_ISEL_OFF        2'h0
`define ASCG_ISEL_CONV       2'h1
`define ASCG_ISEL_SEQ        2'h2
`define ASCG_ISEL_RSV        2'h3
`define ASCG_OSEL_HIZ        3'h0
`define ASCG_OSEL_IRQ_LOW    3'h1
`define ASCG_OSEL_IRQ_HIGH   3'h2
`define ASCG_OSEL_ZERO       3'h3
`define ASCG_OSEL_ONE        3'h4
`define ASCG_OSEL_SWITCH     3'h5
`define ASCG_OSEL_MOD        3'h6
`define ASCG_OSEL_SYSCLK     3'h7
`define ASCG_PIN0_RST_VAL    8'h00

// timing: clock rate, wakeup time, system clock output
`define ASCG_CLK_MHZ         100
`define ASCG_WAKE_TIME_NS    1000
`define ASCG_WAKE_CYC        ((`ASCG_WAKE_TIME_NS * `ASCG_CLK_MHZ + 999) / 1000)
`define ASCG_SYSCLK_KHZ      2456
`define ASCG_SYSCLK_HALF     ((`ASCG_CLK_MHZ * 1000) / (2 * `ASCG_SYSCLK_KHZ))

`endif

// ===== logic/ascg_pin_sync.v
// two-flop synchroniser with rising-edge detect for one pin
`timescale 1ns/100ps
`include "ascg_map.vh"

module ascg_pin_sync
(
	input  wire clk,
	input  wire rst,
	input  wire pin_in,
	output wire level,
	output wire rise
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// meta_r feeds only sync_r
	always @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// (RQ18) two-period pulses always seen
	assign level = sync_r;
	assign rise  = sync_r & ~prev_r;

endmodule

// ===== logic/ascg_clk_div.v
// divider making the system clock level for the pin output
`timescale 1ns/100ps
`include "ascg_map.vh"

module ascg_clk_div
(
	input  wire clk,
	input  wire rst,
	input  wire enable,
	output wire clk_level
);

	localparam integer HALF_CYC_LAST = `ASCG_SYSCLK_HALF - 1;
	localparam [5:0] HALF_LAST = HALF_CYC_LAST[5:0];

	reg [5:0] cnt_r;
	reg       lvl_r;

	// (RQ22) toggle every half period
	always @(posedge clk)
	begin
		if (rst || !enable)
		begin
			cnt_r <= 6'h00;
			lvl_r <= 1'b0;
		end
		else if (cnt_r == HALF_LAST)
		begin
			cnt_r <= 6'h00;
			lvl_r <= ~lvl_r;
		end
		else
		begin
			cnt_r <= cnt_r + 6'h01;
		end
	end

	assign clk_level = lvl_r;

endmodule

// ===== logic/ascg_top.v
// start-command, calibration-start and pin0 control registers behind the serial port
// Overview of operation
// (RQ1) writing sequence start launches the sequencer at the written address
// (RQ2) a start during a running sequence acts as an unconditional jump
// (RQ3) addresses outside 0x3A to 0x6E are ignored, nothing starts
// (RQ4) sequence start in standby or sleep wakes first, then runs
// (RQ5) writing calibration start launches the type in bits 2:0
// (RQ6) calibration values are stored only on successful completion
// (RQ7) filter type and rate are frozen at calibration start
// (RQ8) calibration start in standby or sleep wakes first
// (RQ9) type 000 self-calibrates into self offset and gain-1 gain
// (RQ10) type 001 calibrates current PGA gain, no-op if path off or 1x
// (RQ11) host must not use reserved types 010 and 011
// (RQ12) types 100 and 101 store system offset and gain set A
// (RQ13) types 110 and 111 store system offset and gain set B
// (RQ14) pin0 control writes holding a reserved code are dropped
// (RQ15) direction: 00 input, 01 reserved, 10 open drain, 11 push-pull
// (RQ16) input function: off, edge conversion start, edge sequence start, reserved
// (RQ17) pin start edge in standby or sleep wakes first, then starts
// (RQ18) external start pulses last at least two clock periods
// (RQ19) output function 000 high-z, 001 low irq, 010 high irq
// (RQ20) codes 011 and 100 drive constant 0 and 1
// (RQ21) 101 low-side switch, 110 modulator active, 111 system clock
// (RQ22) system clock output runs near 2.456 MHz
// (RQ23) output function acts only as output, input function only as input
// (RQ24) power state 00 normal, 01 standby, 10 sleep, 11 reset to standby
// (RQ25) wakeup reads 10, starts held until timer expires, then 00
// (RQ26) pin conversion uses pin destination and type fields
// (RQ27) pin sequence starts at pin sequence address, reset 0x3A
// (RQ28) edges ignored while input disabled or pin is output
`timescale 1ns/100ps
`include "ascg_map.vh"

module ascg_top
(
	input  wire        clk,
	input  wire        rst,
	input  wire        spi_csb_n,
	input  wire        spi_sclk,
	input  wire        spi_sdi,
	output wire        spi_sdo,
	output wire        spi_sdo_oe_n,
	input  wire        pin0_in,
	output wire        pin0_out,
	output wire        pin0_oe_n,
	input  wire        seq_running,
	input  wire        irq_level,
	input  wire        lowside_switch_on,
	input  wire        modulator_active,
	input  wire        cal_done,
	input  wire        cal_ok,
	input  wire [23:0] cal_offset_val,
	input  wire [23:0] cal_gain_val,
	output wire [1:0]  power_state,
	output reg         seq_go,
	output reg         seq_go_jump,
	output reg  [6:0]  seq_go_addr,
	output reg         conv_go,
	output reg  [2:0]  conv_go_dest,
	output reg  [1:0]  conv_go_type,
	output reg         cal_go,
	output reg  [2:0]  cal_go_type,
	output reg  [1:0]  cal_filter_type,
	output reg  [3:0]  cal_rate,
	output reg  [2:0]  cal_pga_gain,
	output reg         cal_off_we,
	output reg  [1:0]  cal_off_sel,
	output reg  [23:0] cal_off_data,
	output reg         cal_gain_we,
	output reg  [3:0]  cal_gain_sel,
	output reg  [23:0] cal_gain_data
);

	localparam [1:0] ST_READY = 2'b01;
	localparam [1:0] ST_WAKE  = 2'b10;
	localparam integer WAKE_CYC_LAST = `ASCG_WAKE_CYC - 1;
	localparam [6:0] WAKE_LAST = WAKE_CYC_LAST[6:0];

	wire [3:0] pin_raw;
	wire [3:0] pin_lvl;
	wire [3:0] pin_rise;
	wire       csb_n_lvl;
	wire       sclk_rise;
	wire       sdi_lvl;
	wire       p0_rise;
	wire       sysclk_lvl;

	reg        soft_clr_r;
	reg  [1:0] power_r;
	reg  [1:0] state_r;
	reg  [6:0] wake_cnt_r;
	reg  [7:0] conv_r;
	reg  [6:0] seq_r;
	reg  [2:0] cal_r;
	reg  [7:0] pin0_r;
	reg  [7:0] gpconv_r;
	reg  [6:0] gpseq_r;
	reg  [6:0] filter_r;
	reg  [7:0] pga_r;
	reg  [4:0] bit_cnt_r;
	reg  [7:0] shin_r;
	reg  [7:0] cmd_r;
	reg  [7:0] tx_r;
	reg        sdo_r;
	reg        wr_r;
	reg  [6:0] wa_r;
	reg  [7:0] wd_r;
	reg        pend_seq_r;
	reg  [6:0] pend_sequence_entry_address_r;
	reg        pend_conv_r;
	reg  [4:0] pend_conv_r_fields;
	reg        pend_cal_r;
	reg  [11:0] pend_cal_fields_r;
	reg  [2:0] act_type_r;
	reg  [2:0] act_gain_r;
	reg        pin_out_r;
	reg        pin_oe_n_r;

	assign pin_raw = {pin0_in, spi_sdi, spi_sclk, ~spi_csb_n}; // select inverted so reset reads idle

	// synchronise every outside pin
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_sync
			ascg_pin_sync u_sync
			(
				.clk    (clk),
				.rst    (rst),
				.pin_in (pin_raw[gi]),
				.level  (pin_lvl[gi]),
				.rise   (pin_rise[gi])
			);
		end
	endgenerate

	assign csb_n_lvl = ~pin_lvl[0];
	assign sclk_rise = pin_rise[1];
	assign sdi_lvl   = pin_lvl[2];
	assign p0_rise   = pin_rise[3];

	reg  sclk_prev_r;
	wire sclk_fall = ~pin_lvl[1] & sclk_prev_r;
	wire cfg_clr = rst | soft_clr_r;

	// register read decode
	function [7:0] rd_mux;
		input [6:0] a;
		begin
			if (a == `ASCG_ADDR_POWER)
				rd_mux = {6'h00, power_state};
			else if (a == `ASCG_ADDR_CONV)
				rd_mux = conv_r;
			else if (a == `ASCG_ADDR_SEQ)
				rd_mux = {1'b0, seq_r};
			else if (a == `ASCG_ADDR_CAL)
				rd_mux = {5'h00, cal_r};
			else if (a == `ASCG_ADDR_PIN0)
				rd_mux = pin0_r;
			else if (a == `ASCG_ADDR_GPCONV)
				rd_mux = gpconv_r;
			else if (a == `ASCG_ADDR_GPSEQ)
				rd_mux = {1'b0, gpseq_r};
			else if (a == `ASCG_ADDR_FILTER)
				rd_mux = {1'b0, filter_r};
			else if (a == `ASCG_ADDR_PGA)
				rd_mux = pga_r;
			else
				rd_mux = 8'h00;
		end
	endfunction

	// serial frame: command byte then one data byte
	always @(posedge clk)
	begin
		sclk_prev_r <= rst ? 1'b0 : pin_lvl[1];
		if (rst || csb_n_lvl)
		begin
			bit_cnt_r <= 5'h00;
			shin_r    <= 8'h00;
			cmd_r     <= 8'h00;
			tx_r      <= 8'h00;
			sdo_r     <= 1'b0;
			wr_r      <= 1'b0;
			wa_r      <= 7'h00;
			wd_r      <= 8'h00;
		end
		else
		begin
			wr_r <= 1'b0;
			if (sclk_rise && bit_cnt_r < `ASCG_FRAME_BITS)
			begin
				shin_r    <= {shin_r[6:0], sdi_lvl};
				bit_cnt_r <= bit_cnt_r + 5'h01;
				if (bit_cnt_r == `ASCG_CMD_LAST_BIT)
				begin
					cmd_r <= {shin_r[6:0], sdi_lvl};
					tx_r  <= rd_mux({shin_r[5:0], sdi_lvl});
				end
				if (bit_cnt_r == `ASCG_DATA_LAST_BIT && !cmd_r[`ASCG_FRAME_RW_BIT])
				begin
					wr_r <= 1'b1;
					wa_r <= cmd_r[6:0];
					wd_r <= {shin_r[6:0], sdi_lvl};
				end
			end
			if (sclk_fall && bit_cnt_r > `ASCG_CMD_LAST_BIT)
			begin
				sdo_r <= tx_r[7];
				tx_r  <= {tx_r[6:0], 1'b0};
			end
		end
	end

	assign spi_sdo      = sdo_r;
	assign spi_sdo_oe_n = csb_n_lvl;

	// write qualifiers
	wire w_power  = wr_r && wa_r == `ASCG_ADDR_POWER;
	wire w_conv   = wr_r && wa_r == `ASCG_ADDR_CONV;
	// (RQ3) range check on sequence address
	wire w_seq    = wr_r && wa_r == `ASCG_ADDR_SEQ && wd_r[6:0] >= `ASCG_SEQ_MIN && wd_r[6:0] <= `ASCG_SEQ_MAX;
	wire w_cal    = wr_r && wa_r == `ASCG_ADDR_CAL;
	wire [2:0] w_cal_type = wd_r[2:0];
	// (RQ10) pga calibration is a no-op when path off or gain 1x
	wire cal_noop = (w_cal_type == `ASCG_CAL_PGA) &&
		(pga_r[5:4] != `ASCG_PATH_PGA || pga_r[2:0] == `ASCG_GAIN_1X);
	wire cal_rsv  = (w_cal_type == `ASCG_CAL_RSV0) || (w_cal_type == `ASCG_CAL_RSV1);
	// (RQ14) reserved direction or input code drops the write
	wire w_pin0   = wr_r && wa_r == `ASCG_ADDR_PIN0 &&
		wd_r[`ASCG_DIR_MSB:`ASCG_DIR_LSB] != `ASCG_DIR_RSV &&
		wd_r[`ASCG_ISEL_MSB:`ASCG_ISEL_LSB] != `ASCG_ISEL_RSV;
	wire w_gpseq  = wr_r && wa_r == `ASCG_ADDR_GPSEQ && wd_r[6:0] >= `ASCG_SEQ_MIN && wd_r[6:0] <= `ASCG_GPSEQ_MAX;

	// configuration registers
	always @(posedge clk)
	begin
		if (cfg_clr)
		begin
			conv_r   <= 8'h00;
			seq_r    <= 7'h00;
			cal_r    <= 3'h0;
			pin0_r   <= `ASCG_PIN0_RST_VAL;
			gpconv_r <= 8'h00;
			// (RQ27) pin sequence address reset
			gpseq_r  <= `ASCG_GPSEQ_RST_VAL;
			filter_r <= 7'h00;
			pga_r    <= 8'h00;
		end
		else
		begin
			if (w_conv)
				conv_r <= {1'b0, wd_r[6:4], 2'h0, wd_r[1:0]};
			if (w_seq)
				seq_r <= wd_r[6:0];
			if (w_cal)
				cal_r <= w_cal_type;
			if (w_pin0)
				pin0_r <= {wd_r[7:4], 1'b0, wd_r[2:0]};
			if (wr_r && wa_r == `ASCG_ADDR_GPCONV)
				gpconv_r <= {1'b0, wd_r[6:4], 2'h0, wd_r[1:0]};
			if (w_gpseq)
				gpseq_r <= wd_r[6:0];
			if (wr_r && wa_r == `ASCG_ADDR_FILTER)
				filter_r <= wd_r[6:0];
			if (wr_r && wa_r == `ASCG_ADDR_PGA)
				pga_r <= {2'h0, wd_r[5:4], 1'b0, wd_r[2:0]};
		end
	end

	// (RQ16) (RQ23) (RQ28) edges count only in input mode with a start function
	wire in_mode  = pin0_r[`ASCG_DIR_MSB:`ASCG_DIR_LSB] == `ASCG_DIR_IN;
	wire pin_conv = p0_rise && in_mode && pin0_r[`ASCG_ISEL_MSB:`ASCG_ISEL_LSB] == `ASCG_ISEL_CONV;
	wire pin_seq  = p0_rise && in_mode && pin0_r[`ASCG_ISEL_MSB:`ASCG_ISEL_LSB] == `ASCG_ISEL_SEQ;

	// (RQ26) (RQ27) merge register and pin start requests
	wire       req_seq   = w_seq | pin_seq;
	wire [6:0] rq_saddr  = w_seq ? wd_r[6:0] : gpseq_r;
	wire       req_conv  = w_conv | pin_conv;
	wire [4:0] rq_conv   = w_conv ? {wd_r[6:4], wd_r[1:0]} : {gpconv_r[6:4], gpconv_r[1:0]};
	wire       req_cal   = w_cal && !cal_rsv && !cal_noop;
	// (RQ7) freeze filter, rate and gain at the request
	wire [11:0] rq_cal   = {w_cal_type, filter_r[5:4], filter_r[3:0], pga_r[2:0]};
	wire       any_req   = req_seq | req_conv | req_cal;

	// launch sources: fresh request wins over held one
	wire       f_seq   = req_seq | pend_seq_r;
	wire [6:0] f_saddr = req_seq ? rq_saddr : pend_sequence_entry_address_r;
	wire       f_conv  = req_conv | pend_conv_r;
	wire [4:0] f_cvf   = req_conv ? rq_conv : pend_conv_r_fields;
	wire       f_cal   = req_cal | pend_cal_r;
	wire [11:0] f_clf  = req_cal ? rq_cal : pend_cal_fields_r;
	wire       wake_done = (state_r == ST_WAKE) && wake_cnt_r == 7'h00;
	wire       fire = (state_r == ST_READY && power_r == `ASCG_PS_NORMAL && !w_power && any_req) ||
		(wake_done && !w_power);

	// (RQ24) (RQ25) power state and wakeup sequencing
	always @(posedge clk)
	begin
		if (cfg_clr)
		begin
			power_r    <= rst ? `ASCG_PS_RST_VAL : `ASCG_PS_STANDBY;
			state_r    <= ST_READY;
			wake_cnt_r <= 7'h00;
			soft_clr_r <= 1'b0;
			pend_seq_r <= 1'b0;
			pend_conv_r <= 1'b0;
			pend_cal_r <= 1'b0;
			pend_sequence_entry_address_r <= 7'h00;
			pend_conv_r_fields <= 5'h00;
			pend_cal_fields_r <= 12'h000;
		end
		else if (w_power)
		begin
			// a power write also drops any held start
			soft_clr_r  <= wd_r[1:0] == `ASCG_PS_RESET;
			power_r     <= wd_r[1:0];
			state_r     <= ST_READY;
			pend_seq_r  <= 1'b0;
			pend_conv_r <= 1'b0;
			pend_cal_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_READY:
				begin
					// (RQ4) (RQ8) (RQ17) wake before any start
					if (any_req && power_r != `ASCG_PS_NORMAL)
					begin
						state_r    <= ST_WAKE;
						wake_cnt_r <= WAKE_LAST;
						pend_seq_r <= req_seq;
						pend_conv_r <= req_conv;
						pend_cal_r <= req_cal;
						pend_sequence_entry_address_r <= rq_saddr;
						pend_conv_r_fields <= rq_conv;
						pend_cal_fields_r <= rq_cal;
					end
				end
				ST_WAKE:
				begin
					pend_seq_r  <= f_seq;
					pend_conv_r <= f_conv;
					pend_cal_r  <= f_cal;
					pend_sequence_entry_address_r <= f_saddr;
					pend_conv_r_fields <= f_cvf;
					pend_cal_fields_r <= f_clf;
					wake_cnt_r  <= wake_cnt_r - 7'h01;
					if (wake_done)
					begin
						power_r     <= `ASCG_PS_NORMAL;
						state_r     <= ST_READY;
						pend_seq_r  <= 1'b0;
						pend_conv_r <= 1'b0;
						pend_cal_r  <= 1'b0;
					end
				end
				default:
					state_r <= ST_READY;
			endcase
		end
	end

	assign power_state = (state_r == ST_WAKE) ? `ASCG_PS_WAKE_READ : power_r;

	// (RQ1) (RQ2) (RQ5) start pulses to sequencer, converter, calibrator
	always @(posedge clk)
	begin
		if (cfg_clr)
		begin
			seq_go <= 1'b0;
			seq_go_jump <= 1'b0;
			seq_go_addr <= 7'h00;
			conv_go <= 1'b0;
			conv_go_dest <= 3'h0;
			conv_go_type <= 2'h0;
			cal_go <= 1'b0;
			cal_go_type <= 3'h0;
			cal_filter_type <= 2'h0;
			cal_rate <= 4'h0;
			cal_pga_gain <= 3'h0;
		end
		else
		begin
			seq_go  <= fire & f_seq;
			conv_go <= fire & f_conv;
			cal_go  <= fire & f_cal;
			if (fire && f_seq)
			begin
				seq_go_addr <= f_saddr;
				seq_go_jump <= seq_running;
			end
			if (fire && f_conv)
			begin
				conv_go_dest <= f_cvf[4:2];
				conv_go_type <= f_cvf[1:0];
			end
			if (fire && f_cal)
			begin
				cal_go_type     <= f_clf[11:9];
				cal_filter_type <= f_clf[8:7];
				cal_rate        <= f_clf[6:3];
				cal_pga_gain    <= f_clf[2:0];
			end
		end
	end

	// (RQ6) store results only on successful completion
	always @(posedge clk)
	begin
		if (cfg_clr)
		begin
			act_type_r <= 3'h0;
			act_gain_r <= 3'h0;
			cal_off_we <= 1'b0;
			cal_gain_we <= 1'b0;
			cal_off_sel <= 2'h0;
			cal_gain_sel <= 4'h0;
			cal_off_data <= 24'h000000;
			cal_gain_data <= 24'h000000;
		end
		else
		begin
			cal_off_we  <= 1'b0;
			cal_gain_we <= 1'b0;
			if (fire && f_cal)
			begin
				act_type_r <= f_clf[11:9];
				act_gain_r <= f_clf[2:0];
			end
			if (cal_done && cal_ok)
			begin
				cal_off_data  <= cal_offset_val;
				cal_gain_data <= cal_gain_val;
				case (act_type_r)
					// (RQ9) self offset and unity gain
					`ASCG_CAL_SELF:
					begin
						cal_off_we   <= 1'b1;
						cal_off_sel  <= `ASCG_OFF_SEL_SELF;
						cal_gain_we  <= 1'b1;
						cal_gain_sel <= {1'b0, `ASCG_GAIN_1X};
					end
					// (RQ10) gain slot of current gain
					`ASCG_CAL_PGA:
					begin
						cal_gain_we  <= 1'b1;
						cal_gain_sel <= {1'b0, act_gain_r};
					end
					// (RQ12) system set A
					`ASCG_CAL_SOFF_A:
					begin
						cal_off_we  <= 1'b1;
						cal_off_sel <= `ASCG_OFF_SEL_SYS_A;
					end
					`ASCG_CAL_SGAIN_A:
					begin
						cal_gain_we  <= 1'b1;
						cal_gain_sel <= `ASCG_GAIN_SEL_SYS_A;
					end
					// (RQ13) system set B
					`ASCG_CAL_SOFF_B:
					begin
						cal_off_we  <= 1'b1;
						cal_off_sel <= `ASCG_OFF_SEL_SYS_B;
					end
					`ASCG_CAL_SGAIN_B:
					begin
						cal_gain_we  <= 1'b1;
						cal_gain_sel <= `ASCG_GAIN_SEL_SYS_B;
					end
					default:
					begin
						cal_off_we  <= 1'b0;
						cal_gain_we <= 1'b0;
					end
				endcase
			end
		end
	end

	wire [2:0] osel    = pin0_r[`ASCG_OSEL_MSB:`ASCG_OSEL_LSB];
	wire [1:0] dir     = pin0_r[`ASCG_DIR_MSB:`ASCG_DIR_LSB];
	wire       out_on  = dir[1] && osel != `ASCG_OSEL_HIZ;

	// (RQ22) system clock source
	ascg_clk_div u_div
	(
		.clk       (clk),
		.rst       (rst),
		.enable    (out_on && osel == `ASCG_OSEL_SYSCLK),
		.clk_level (sysclk_lvl)
	);

	// (RQ19) (RQ20) (RQ21) output function value
	reg pin_val;
	always @*
	begin
		case (osel)
			`ASCG_OSEL_IRQ_LOW:  pin_val = ~irq_level;
			`ASCG_OSEL_IRQ_HIGH: pin_val = irq_level;
			`ASCG_OSEL_ZERO:     pin_val = 1'b0;
			`ASCG_OSEL_ONE:      pin_val = 1'b1;
			`ASCG_OSEL_SWITCH:   pin_val = ~lowside_switch_on;
			`ASCG_OSEL_MOD:      pin_val = modulator_active;
			`ASCG_OSEL_SYSCLK:   pin_val = sysclk_lvl;
			default:             pin_val = 1'b0;
		endcase
	end

	// (RQ15) (RQ23) pin drive by direction; switch forces open drain
	always @(posedge clk)
	begin
		if (cfg_clr || !out_on)
		begin
			pin_out_r  <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end
		else if (dir == `ASCG_DIR_OD || osel == `ASCG_OSEL_SWITCH)
		begin
			pin_out_r  <= 1'b0;
			pin_oe_n_r <= pin_val;
		end
		else
		begin
			pin_out_r  <= pin_val;
			pin_oe_n_r <= 1'b0;
		end
	end

	assign pin0_out  = pin_out_r;
	assign pin0_oe_n = pin_oe_n_r;

endmodule

// ===== verif/ascg_host.sv
// serial host model that drives whole frames into the device port
`timescale 1ns/100ps
module ascg_host
(
	input  logic clk,
	input  logic sdo,
	output logic csb_n,
	output logic sclk,
	output logic sdi
);
	// idle: deselected, clock parked low
	initial
	begin
		csb_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end

	// one frame, command byte then data byte, msb first, data set while clock low
	task frame(input logic [15:0] w, output logic [7:0] rd);
		integer i;
		begin
			@(negedge clk);
			csb_n = 1'b0;
			for (i = 15; i >= 0; i = i - 1)
			begin
				sdi = w[i];
				repeat (5) @(negedge clk);
				if (i < 8) rd[i] = sdo;
				sclk = 1'b1;
				repeat (5) @(negedge clk);
				sclk = 1'b0;
			end
			repeat (3) @(negedge clk);
			csb_n = 1'b1;
			// released data line must not look held
			sdi = ~sdi;
			repeat (6) @(negedge clk);
		end
	endtask
endmodule

// ===== verif/ascg_top_sva.sv
// assertions on the start, calibration and store ports of the block
`timescale 1ns/100ps
module ascg_top_sva
(
	input logic        clk,
	input logic        rst,
	input logic        cal_done,
	input logic        cal_ok,
	input logic [23:0] cal_offset_val,
	input logic [1:0]  power_state,
	input logic        seq_go,
	input logic [6:0]  seq_go_addr,
	input logic        conv_go,
	input logic        cal_go,
	input logic [2:0]  cal_go_type,
	input logic        cal_off_we,
	input logic [1:0]  cal_off_sel,
	input logic [23:0] cal_off_data,
	input logic        cal_gain_we,
	input logic [3:0]  cal_gain_sel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// sequence starts are single pulses inside the valid range; every start only when awake
	a_seq_single: assert property (seq_go |=> !seq_go)
		else $error("sequence start wider than one cycle");
	a_seq_range: assert property (seq_go |-> seq_go_addr >= 7'h3A && seq_go_addr <= 7'h6F)
		else $error("sequence start outside microcode range");
	a_seq_awake: assert property (seq_go |-> power_state == 2'h0)
		else $error("sequence start while not awake");
	a_conv_awake: assert property (conv_go |-> power_state == 2'h0)
		else $error("conversion start while not awake");
	a_cal_awake: assert property (cal_go |-> power_state == 2'h0)
		else $error("calibration start while not awake");
	a_cal_legal: assert property (cal_go |-> cal_go_type[2:1] != 2'h1)
		else $error("reserved calibration type launched");

	// stores follow a successful completion by one cycle
	a_store_ok: assert property ((cal_off_we || cal_gain_we) |-> $past(cal_done) && $past(cal_ok))
		else $error("calibration store without success");
	a_off_data: assert property (cal_off_we |-> cal_off_data == $past(cal_offset_val))
		else $error("offset store data differs from result");
	a_self_pair: assert property (cal_off_we && cal_off_sel == 2'h0 |-> cal_gain_we && cal_gain_sel == 4'h0)
		else $error("self calibration did not store both values");
endmodule

// ===== verif/ascg_top_tb.sv
// self-checking bench for the start, calibration and pin0 control registers
`timescale 1ns/100ps
`include "ascg_map.vh"
module ascg_top_tb;
	localparam [7:0]  GOM = 8'hF3, OFM = 8'h51, GAM = 8'hA3;
	localparam [15:0] OST = 16'h2100;
	localparam [31:0] GST = 32'h9080_0030;
	localparam [6:0]  OE1 = 7'h01, OE0 = 7'h21, OU1 = 7'h54, OU0 = 7'h12;
	logic        clk = 1'b0;
	logic        rst, spi_csb_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n, pin0_in, pin0_out, pin0_oe_n;
	logic        seq_running, irq_level, lowside_switch_on, modulator_active, cal_done, cal_ok;
	logic        seq_go, seq_go_jump, conv_go, cal_go, cal_off_we, cal_gain_we;
	logic [23:0] cal_offset_val, cal_gain_val, cal_off_data, cal_gain_data, o_dat, g_dat;
	logic [1:0]  power_state, conv_go_type, cal_filter_type, cal_off_sel, o_sel;
	logic [2:0]  conv_go_dest, cal_go_type, cal_pga_gain;
	logic [3:0]  cal_rate, cal_gain_sel, g_sel;
	logic [6:0]  seq_go_addr;
	logic [7:0]  rdv;
	integer      mismatches = 0, total_checks = 0, n_seq = 0, n_conv = 0, n_cal = 0, n_off = 0, n_gain = 0;
	integer      b0, b1, b2;

	ascg_top dut (.*);
	ascg_host host (.clk(clk), .sdo(spi_sdo), .csb_n(spi_csb_n), .sclk(spi_sclk), .sdi(spi_sdi));

	// 100 MHz clock
	always #5 clk = ~clk;

	// pulse counters and captured store targets
	always @(posedge clk)
	begin
		n_seq <= n_seq + seq_go;
		n_conv <= n_conv + conv_go;
		n_cal <= n_cal + cal_go;
		n_off <= n_off + cal_off_we;
		n_gain <= n_gain + cal_gain_we;
		if (cal_off_we) {o_sel, o_dat} <= {cal_off_sel, cal_off_data};
		if (cal_gain_we) {g_sel, g_dat} <= {cal_gain_sel, cal_gain_data};
	end

	task chk(input logic [31:0] seen, input logic [31:0] want);
		begin
			total_checks = total_checks + 1;
			if (seen !== want)
			begin
				mismatches = mismatches + 1;
				$display("BAD %0t seen %h exp %h", $time, seen, want);
			end
		end
	endtask

	task stop_test;
		begin
			if (mismatches == 0 && total_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task wr(input logic [6:0] a, input logic [7:0] d);
		host.frame({1'b0, a, d}, rdv);
	endtask

	task rd(input logic [6:0] a, input logic [7:0] want);
		begin
			host.frame({1'b1, a, 8'h00}, rdv);
			chk(rdv, want);
		end
	endtask

	task pulse;
		begin
			pin0_in = 1'b1;
			repeat (3) @(negedge clk);
			pin0_in = 1'b0;
			repeat (8) @(negedge clk);
		end
	endtask

	task done(input logic ok);
		begin
			cal_done = 1'b1;
			cal_ok = ok;
			@(negedge clk);
			cal_done = 1'b0;
			repeat (3) @(negedge clk);
		end
	endtask

	task t_seq;
		begin
			b0 = n_seq;
			wr(`ASCG_ADDR_SEQ, 8'h3A);
			chk(power_state, 2'h2);
			chk(n_seq - b0, 0);
			repeat (100) @(negedge clk);
			chk(n_seq - b0, 1);
			chk({seq_go_addr, power_state}, {7'h3A, 2'h0});
			seq_running = 1'b1;
			wr(`ASCG_ADDR_SEQ, 8'h6E);
			chk({seq_go_addr, seq_go_jump}, {7'h6E, 1'b1});
			seq_running = 1'b0;
			wr(`ASCG_ADDR_SEQ, 8'h39);
			wr(`ASCG_ADDR_SEQ, 8'h6F);
			chk(n_seq - b0, 2);
		end
	endtask

	task t_cal;
		integer t;
		begin
			wr(`ASCG_ADDR_FILTER, 8'h2B);
			wr(`ASCG_ADDR_PGA, 8'h23);
			for (t = 0; t < 8; t = (t == 1) ? 4 : t + 1) // reserved types never written
			begin
				{b0, b1, b2} = {n_cal, n_off, n_gain};
				cal_offset_val = {16'h0A00, 5'h00, t[2:0]};
				cal_gain_val = {16'h0B00, 5'h00, t[2:0]};
				wr(`ASCG_ADDR_CAL, t[7:0]);
				chk(n_cal - b0, GOM[t]);
				if (GOM[t])
				begin
					chk({cal_go_type, cal_filter_type, cal_rate, cal_pga_gain}, {t[2:0], 2'h2, 4'hB, 3'h3});
					done(1'b0);
					chk(n_off + n_gain - b1 - b2, 0);
					done(1'b1);
					chk(n_off - b1, OFM[t]);
					chk(n_gain - b2, GAM[t]);
					if (OFM[t]) chk({o_sel, o_dat}, {OST[2*t+:2], cal_offset_val});
					if (GAM[t]) chk({g_sel, g_dat}, {GST[4*t+:4], cal_gain_val});
				end
			end
			wr(`ASCG_ADDR_FILTER, 8'h15);
			chk(cal_rate, 4'hB);
			b0 = n_cal;
			wr(`ASCG_ADDR_PGA, 8'h20);
			wr(`ASCG_ADDR_CAL, 8'h01);
			wr(`ASCG_ADDR_PGA, 8'h03);
			wr(`ASCG_ADDR_CAL, 8'h01);
			chk(n_cal - b0, 0);
		end
	endtask

	task t_pout;
		integer s, c, k;
		logic   p;
		begin
			for (s = 0; s < 2; s = s + 1)
				for (c = 0; c < 7; c = c + 1)
				begin
					{irq_level, modulator_active, lowside_switch_on} = {3{s[0]}};
					wr(`ASCG_ADDR_PIN0, {5'h18, c[2:0]});
					chk(pin0_oe_n, s ? OE1[c] : OE0[c]);
					if (!(s ? OE1[c] : OE0[c])) chk(pin0_out, s ? OU1[c] : OU0[c]);
					if (c == 3 || c == 4) chk(pin0_out, c == 4);
				end
			wr(`ASCG_ADDR_PIN0, 8'h44);
			wr(`ASCG_ADDR_PIN0, 8'hF0);
			rd(`ASCG_ADDR_PIN0, 8'hC6);
			wr(`ASCG_ADDR_PIN0, 8'h04);
			chk(pin0_oe_n, 1'b1);
			wr(`ASCG_ADDR_PIN0, 8'h83);
			chk({pin0_oe_n, pin0_out}, 2'b00);
			wr(`ASCG_ADDR_PIN0, 8'hC7);
			k = 0;
			p = pin0_out;
			repeat (400)
			begin
				@(negedge clk);
				k = k + (pin0_out !== p);
				p = pin0_out;
			end
			chk(k >= 19 && k <= 21, 1);
		end
	endtask

	task t_pin_in;
		begin
			{b0, b1} = {n_conv, n_seq};
			wr(`ASCG_ADDR_GPCONV, 8'h51);
			wr(`ASCG_ADDR_GPSEQ, 8'h45);
			wr(`ASCG_ADDR_PIN0, 8'h10);
			pulse;
			chk(n_conv - b0, 1);
			chk({conv_go_dest, conv_go_type}, {3'h5, 2'h1});
			wr(`ASCG_ADDR_PIN0, 8'h20);
			wr(`ASCG_ADDR_POWER, 8'h01);
			pulse;
			chk(power_state, 2'h2);
			chk(n_seq - b1, 0);
			repeat (100) @(negedge clk);
			chk({seq_go_addr, seq_go_jump, power_state}, {7'h45, 1'b0, 2'h0});
			chk(n_seq - b1, 1);
			wr(`ASCG_ADDR_PIN0, 8'h00);
			pulse;
			wr(`ASCG_ADDR_PIN0, 8'hE0);
			pulse;
			chk(n_seq - b1 + n_conv - b0, 2);
		end
	endtask

	// reset, scenarios, verdict
	initial
	begin
		rst = 1'b1;
		{pin0_in, seq_running, irq_level, lowside_switch_on, modulator_active, cal_done, cal_ok} = 7'h00;
		{cal_offset_val, cal_gain_val} = 48'h0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk({power_state, pin0_oe_n, spi_sdo_oe_n}, 4'hB);
		rd(`ASCG_ADDR_PIN0, 8'h00);
		rd(`ASCG_ADDR_GPSEQ, 8'h3A);
		t_seq;
		t_cal;
		t_pout;
		t_pin_in;
		wr(`ASCG_ADDR_POWER, 8'h03);
		chk(power_state, 2'h1);
		rd(`ASCG_ADDR_PIN0, 8'h00);
		stop_test;
	end

	// cut a hang short well past the expected run length
	initial
	begin
		#900000;
		mismatches = mismatches + 1;
		stop_test;
	end
endmodule

bind ascg_top ascg_top_sva u_sva (.*);
